// ### rtl/ias_pkg.sv
package ias_pkg;

	// ==========================================
	// sizes
	localparam int IAS_LEVELS = 8;
	localparam int IAS_LVL_W  = 3;

	// ==========================================
	// register offsets
	localparam logic [7:0] IAS_OFF_CTRL  = 8'h00;
	localparam logic [7:0] IAS_OFF_MASK  = 8'h04;
	localparam logic [7:0] IAS_OFF_VBASE = 8'h08;
	localparam logic [7:0] IAS_OFF_RADDR = 8'h0C;
	localparam logic [7:0] IAS_OFF_PEND  = 8'h10;
	localparam logic [7:0] IAS_OFF_INSV  = 8'h14;
	localparam logic [7:0] IAS_OFF_EOI   = 8'h18;

	// ==========================================
	// control field positions
	localparam int IAS_CTRL_VEC  = 0;
	localparam int IAS_CTRL_AUTO_END_OF_SERVICE = 1;
	localparam int IAS_CTRL_CASM = 2;
	localparam int IAS_CTRL_INT8 = 3;
	localparam int IAS_CTRL_BUSY = 8;
	localparam int IAS_VBASE_LSB = 3;
	localparam int IAS_RADDR_LSB = 5;

	// ==========================================
	// reset values and codes
	localparam logic       IAS_VEC_RST   = 1'b0;
	localparam logic       IAS_AUTO_END_OF_SERVICE_RST  = 1'b0;
	localparam logic       IAS_CASM_RST  = 1'b0;
	localparam logic       IAS_INT8_RST  = 1'b0;
	localparam logic [7:0] IAS_MASK_RST  = 8'h00;
	localparam logic [4:0] IAS_VBASE_RST = 5'h00;
	localparam logic [10:0] IAS_RADDR_RST = 11'h000;
	localparam logic [7:0] IAS_CALL_OPC  = 8'hCD;
	localparam logic [2:0] IAS_SPUR_LVL  = 3'h7;

	// ==========================================
	// types
	typedef enum logic [1:0] {
		AS_IDLE,
		AS_BYTE1,
		AS_BYTE2,
		AS_BYTE3
	} ias_seq_t;

	typedef struct packed {
		logic [7:0]  req_s1;
		logic [7:0]  req_s2;
		logic [7:0]  req_p;
		logic        ack_s1;
		logic        ack_s2;
		logic        ack_p;
		logic [7:0]  pend;
		logic [7:0]  insv;
		logic [7:0]  mask;
		logic        vec_mode;
		logic        auto_end_of_service;
		logic        cas_master;
		logic        int8;
		logic [4:0]  vbase;
		logic [10:0] raddr;
		ias_seq_t    seq;
		logic [2:0]  level;
		logic        fmode;
		logic        fvalid;
		logic [7:0]  data;
		logic        data_oe;
		logic [2:0]  cas;
		logic        cas_oe;
		logic        int_o;
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
	} ias_state_t;

endpackage

// ### rtl/ias_sequencer.sv
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
// Contract
// - exactly one acknowledge mode at a time, three-pulse jump or one-byte index
// - after reset the three-pulse jump mode is selected
// - a rising request line sets its pending bit
// - interrupt output only for unmasked pending request of sufficient priority
// - jump mode first strobe sets in-service, clears pending, drives 0xCD
// - jump mode drives low address byte, then high address byte
// - routine addresses come from stored programmable values
// - jump mode auto end-of-service clears in-service at third strobe end
// - index mode keeps data bus released during first strobe
// - first strobe freezes the chosen level against later request changes
// - cascade master drives level code at end of first strobe
// - index mode sets in-service and clears pending after first strobe
// - index mode drives 8-bit index byte on second strobe
// - upper index bits come from a stored value
// - index mode auto end-of-service clears in-service at second strobe end
// - without auto end-of-service in-service holds until end-of-service command
// - low three index bits are the serviced request line number
// - 8-bit mask register, set bit blocks its line from interrupt
module ias_sequencer
	import ias_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	// clock and reset
	input  wire logic              ref_clk,
	input  wire logic              rst,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// interrupt pins
	input  wire logic [7:0]        request_lines,
	input  wire logic              ack_strobe_n,
	output logic                   int_out,
	// data bus toward host
	output logic      [7:0]        data_out,
	output logic                   data_oe,
	// cascade
	output logic      [2:0]        cascade_code_lines,
	output logic                   cascade_oe
);

	// ==========================================
	// helpers
	function automatic logic [2:0] ias_pick(input logic [7:0] v);
		logic [2:0] r;
		r = IAS_SPUR_LVL;
		for (int i = 7; i >= 0; i--) begin
			if (v[i]) begin
				r = 3'(i);
			end
		end
		return r;
	endfunction

	function automatic logic [7:0] ias_dec(input logic [2:0] l);
		logic [7:0] r;
		r = 8'h00;
		r[l] = 1'b1;
		return r;
	endfunction

	// ==========================================
	// state
	ias_state_t s_q;
	ias_state_t s_d;

	logic [7:0]        rq_rise;
	logic              ack_fall;
	logic              ack_rise;
	logic [7:0]        cand;
	logic [2:0]        lvl;
	logic              last;
	logic [7:0]        pend_set;
	logic [7:0]        pend_clr;
	logic [7:0]        isr_set;
	logic [7:0]        isr_clr;
	logic [7:0]        lo_byte;
	logic [7:0]        idx_byte;
	logic              access;
	logic              wr;
	logic [7:0]        off;

	// ==========================================
	// next state
	always_comb begin
		s_d = s_q;
		s_d.req_s1 = request_lines;
		s_d.req_s2 = s_q.req_s1;
		s_d.req_p  = s_q.req_s2;
		s_d.ack_s1 = ack_strobe_n;
		s_d.ack_s2 = s_q.ack_s1;
		s_d.ack_p  = s_q.ack_s2;
		rq_rise  = s_q.req_s2 & ~s_q.req_p;
		ack_fall = s_q.ack_p & ~s_q.ack_s2;
		ack_rise = ~s_q.ack_p & s_q.ack_s2;
		pend_set = rq_rise;
		pend_clr = 8'h00;
		isr_set  = 8'h00;
		isr_clr  = 8'h00;
		cand = s_q.pend & ~s_q.mask;
		lvl  = ias_pick(cand);
		last = s_q.fmode ? (s_q.seq == AS_BYTE2) : (s_q.seq == AS_BYTE3);
		if (s_q.int8) begin
			lo_byte = {s_q.raddr[2:1], s_q.level, 3'b000};
		end else begin
			lo_byte = {s_q.raddr[2:0], s_q.level, 2'b00};
		end
		idx_byte = {s_q.vbase, s_q.level};

		// ==========================================
		// strobe leading edge
		if (ack_fall) begin
			case (s_q.seq)
				AS_IDLE: begin
					s_d.seq = AS_BYTE1;
					s_d.level  = lvl;
					s_d.fvalid = (cand != 8'h00);
					s_d.fmode = s_q.vec_mode;
					if (!s_q.vec_mode) begin
						s_d.data    = IAS_CALL_OPC;
						s_d.data_oe = 1'b1;
						if (cand != 8'h00) begin
							isr_set  = ias_dec(lvl);
							pend_clr = ias_dec(lvl);
						end
					end
					else begin
						s_d.data_oe = 1'b0;
					end
				end
				AS_BYTE1: begin
					s_d.seq     = AS_BYTE2;
					s_d.data_oe = 1'b1;
					if (s_q.fmode) begin
						s_d.data = idx_byte;
					end else begin
						s_d.data = lo_byte;
					end
				end
				AS_BYTE2: begin
					if (!s_q.fmode) begin
						s_d.seq     = AS_BYTE3;
						s_d.data    = s_q.raddr[10:3];
						s_d.data_oe = 1'b1;
					end
				end
				default: begin
					s_d.seq = s_q.seq;
				end
			endcase
		end

		// ==========================================
		// strobe trailing edge
		if (ack_rise) begin
			s_d.data_oe = 1'b0;
			if (s_q.seq == AS_BYTE1) begin
				if (s_q.fmode && s_q.fvalid) begin
					isr_set  = ias_dec(s_q.level);
					pend_clr = ias_dec(s_q.level);
				end
				if (s_q.cas_master) begin
					s_d.cas    = s_q.level;
					s_d.cas_oe = 1'b1;
				end
			end
			if (last) begin
				s_d.seq    = AS_IDLE;
				s_d.cas_oe = 1'b0;
				if (s_q.auto_end_of_service && s_q.fvalid) begin
					isr_clr = ias_dec(s_q.level);
				end
			end
		end

		// ==========================================
		// apb slave
		access    = psel & penable;
		wr        = access & pwrite & s_q.pready;
		off       = 8'(paddr);
		s_d.pready = access & ~s_q.pready;
		s_d.prdata  = 32'h0000_0000;
		s_d.pslverr = 1'b0;
		if (access && !s_q.pready) begin
			case (off)
				IAS_OFF_CTRL: begin
					s_d.prdata[IAS_CTRL_VEC]  = s_q.vec_mode;
					s_d.prdata[IAS_CTRL_AUTO_END_OF_SERVICE] = s_q.auto_end_of_service;
					s_d.prdata[IAS_CTRL_CASM] = s_q.cas_master;
					s_d.prdata[IAS_CTRL_INT8] = s_q.int8;
					s_d.prdata[IAS_CTRL_BUSY] = (s_q.seq != AS_IDLE);
				end
				IAS_OFF_MASK: begin
					s_d.prdata[7:0] = s_q.mask;
				end
				IAS_OFF_VBASE: begin
					s_d.prdata[7:IAS_VBASE_LSB] = s_q.vbase;
				end
				IAS_OFF_RADDR: begin
					s_d.prdata[15:IAS_RADDR_LSB] = s_q.raddr;
				end
				IAS_OFF_PEND: begin
					s_d.prdata[7:0] = s_q.pend;
				end
				IAS_OFF_INSV: begin
					s_d.prdata[7:0] = s_q.insv;
				end
				IAS_OFF_EOI: begin
					s_d.prdata = 32'h0000_0000;
				end
				default: begin
					s_d.pslverr = 1'b1;
				end
			endcase
		end
		if (wr) begin
			case (off)
				IAS_OFF_CTRL: begin
					s_d.vec_mode   = pwdata[IAS_CTRL_VEC];
					s_d.auto_end_of_service       = pwdata[IAS_CTRL_AUTO_END_OF_SERVICE];
					s_d.cas_master = pwdata[IAS_CTRL_CASM];
					s_d.int8       = pwdata[IAS_CTRL_INT8];
				end
				IAS_OFF_MASK: begin
					s_d.mask = pwdata[7:0];
				end
				IAS_OFF_VBASE: begin
					s_d.vbase = pwdata[7:IAS_VBASE_LSB];
				end
				IAS_OFF_RADDR: begin
					s_d.raddr = pwdata[15:IAS_RADDR_LSB];
				end
				IAS_OFF_EOI: begin
					isr_clr = isr_clr | pwdata[7:0];
				end
				default: begin
					s_d.mask = s_q.mask;
				end
			endcase
		end

		// ==========================================
		// pending and in-service, set wins
		s_d.pend = (s_q.pend & ~pend_clr) | pend_set;
		s_d.insv = (s_q.insv & ~isr_clr) | isr_set;

		s_d.int_o = (s_q.seq == AS_IDLE) && (cand != 8'h00) &&
			((s_q.insv == 8'h00) || (lvl < ias_pick(s_q.insv)));
	end

	// ==========================================
	// registers
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s_q            <= '0;
			s_q.req_s1     <= 8'h00;
			s_q.ack_s1     <= 1'b1;
			s_q.ack_s2     <= 1'b1;
			s_q.ack_p      <= 1'b1;
			s_q.mask       <= IAS_MASK_RST;
			s_q.vec_mode   <= IAS_VEC_RST;
			s_q.auto_end_of_service       <= IAS_AUTO_END_OF_SERVICE_RST;
			s_q.cas_master <= IAS_CASM_RST;
			s_q.int8       <= IAS_INT8_RST;
			s_q.vbase      <= IAS_VBASE_RST;
			s_q.raddr      <= IAS_RADDR_RST;
			s_q.seq        <= AS_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================
	// outputs
	assign prdata             = s_q.prdata;
	assign pready             = s_q.pready;
	assign pslverr            = s_q.pslverr;
	assign int_out            = s_q.int_o;
	assign data_out           = s_q.data;
	assign data_oe            = s_q.data_oe;
	assign cascade_code_lines = s_q.cas;
	assign cascade_oe         = s_q.cas_oe;

endmodule

// ### sim/ias_props.sv
`timescale 1ns/1ps
// ====
// port checker
module ias_props
	import ias_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	// clock and reset
	input wire logic              ref_clk,
	input wire logic              rst,
	// apb
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	// pins
	input wire logic [7:0]        request_lines,
	input wire logic              ack_strobe_n,
	input wire logic              int_out,
	input wire logic [7:0]        data_out,
	input wire logic              data_oe,
	input wire logic [2:0]        cascade_code_lines,
	input wire logic              cascade_oe
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	oe_needs_ack_a: assert property ($rose(data_oe) |-> !$past(ack_strobe_n, 2))
		else $error("data bus driven without strobe");
	oe_release_a: assert property ($rose(ack_strobe_n) |-> ##[1:5] !data_oe)
		else $error("data bus held after strobe");
	int_quiet_a: assert property (data_oe && $past(data_oe) |-> !int_out)
		else $error("interrupt during acknowledge");
	int_rise_a: assert property ($rose(int_out) |-> $past(ack_strobe_n, 3))
		else $error("interrupt raised inside strobe");
	one_wait_a: assert property (psel && penable && !pready |=> pready)
		else $error("apb answer late");
	err_pair_a: assert property (pslverr |-> pready)
		else $error("error without ready");
	rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside answer");
	cas_late_a: assert property ($rose(cascade_oe) |-> $past(ack_strobe_n, 2))
		else $error("cascade code too early");
	cover property (data_oe);
	cover property (cascade_oe);
	cover property (pslverr);
endmodule
bind ias_sequencer ias_props #(.ADDR_W(ADDR_W)) u_props (
	.ref_clk            (ref_clk),
	.rst                (rst),
	.psel               (psel),
	.penable            (penable),
	.pwrite             (pwrite),
	.paddr              (paddr),
	.pwdata             (pwdata),
	.prdata             (prdata),
	.pready             (pready),
	.pslverr            (pslverr),
	.request_lines      (request_lines),
	.ack_strobe_n       (ack_strobe_n),
	.int_out            (int_out),
	.data_out           (data_out),
	.data_oe            (data_oe),
	.cascade_code_lines (cascade_code_lines),
	.cascade_oe         (cascade_oe)
);

// ### sim/ias_host.sv
`timescale 1ns/1ps
// ====
// host acknowledge model
module ias_host (
	// pins
	input  wire logic       ref_clk,
	input  wire logic [7:0] data_out,
	input  wire logic       data_oe,
	output logic            ack_strobe_n
);
	initial ack_strobe_n = 1'b1;
	task automatic ack(output logic [7:0] b, output logic o);
		ack_strobe_n <= 1'b0;
		repeat (6) @(posedge ref_clk);
		b = data_out;
		o = data_oe;
		ack_strobe_n <= 1'b1;
		repeat (6) @(posedge ref_clk);
	endtask
endmodule

// ### sim/tb_top.sv
`timescale 1ns/1ps
module tb_top
	import ias_pkg::*;
;
	// ====
	// signals
	logic        ref_clk       = 1'b0;
	logic        rst           = 1'b1;
	logic        psel          = 1'b0;
	logic        penable       = 1'b0;
	logic        pwrite        = 1'b0;
	logic [7:0]  paddr         = 8'h00;
	logic [31:0] pwdata        = 32'h0;
	logic [7:0]  request_lines = 8'h00;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        ack_strobe_n;
	logic        int_out;
	logic [7:0]  data_out;
	logic        data_oe;
	logic [2:0]  cascade_code_lines;
	logic        cascade_oe;
	logic [31:0] r;
	logic [31:0] e;
	logic [7:0]  b;
	logic        o;
	int          n_fail        = 0;
	int          total_checks  = 0;
	always #25 ref_clk = ~ref_clk;
	ias_sequencer dut (
		.ref_clk            (ref_clk),
		.rst                (rst),
		.psel               (psel),
		.penable            (penable),
		.pwrite             (pwrite),
		.paddr              (paddr),
		.pwdata             (pwdata),
		.prdata             (prdata),
		.pready             (pready),
		.pslverr            (pslverr),
		.request_lines      (request_lines),
		.ack_strobe_n       (ack_strobe_n),
		.int_out            (int_out),
		.data_out           (data_out),
		.data_oe            (data_oe),
		.cascade_code_lines (cascade_code_lines),
		.cascade_oe         (cascade_oe)
	);
	ias_host host (
		.ref_clk      (ref_clk),
		.data_out     (data_out),
		.data_oe      (data_oe),
		.ack_strobe_n (ack_strobe_n)
	);
	// ====
	// tasks
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		total_checks++;
		if (s !== x) begin
			n_fail++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1) begin
			@(posedge ref_clk);
		end
		r = prdata;
		e = {31'h0, pslverr};
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(r, x);
	endtask
	task automatic wint();
		int n;
		n = 0;
		while (int_out !== 1'b1 && n < 20) begin
			@(posedge ref_clk);
			n++;
		end
		chk(32'(int_out), 32'h1);
	endtask
	task automatic final_report();
		$display("checks %0d fails %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// ====
	// tests
	initial begin
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (4) @(posedge ref_clk);
		rd(IAS_OFF_CTRL, 32'h0);
		rd(IAS_OFF_MASK, 32'h0);
		apb(1'b0, 8'h1C, 32'h0);
		chk(e, 32'h1);
		$display("test reset done");
		apb(1'b1, IAS_OFF_RADDR, 32'hABE0);
		request_lines <= 8'h28;
		wint();
		rd(IAS_OFF_PEND, 32'h28);
		host.ack(b, o);
		chk(32'(b), 32'hCD);
		chk(32'(o), 32'h1);
		request_lines <= 8'h20;
		host.ack(b, o);
		chk(32'(b), 32'hEC);
		host.ack(b, o);
		chk(32'(b), 32'hAB);
		rd(IAS_OFF_INSV, 32'h08);
		rd(IAS_OFF_PEND, 32'h20);
		apb(1'b1, IAS_OFF_EOI, 32'h08);
		rd(IAS_OFF_INSV, 32'h0);
		$display("test jump done");
		apb(1'b1, IAS_OFF_CTRL, 32'h3);
		apb(1'b1, IAS_OFF_VBASE, 32'hA8);
		wint();
		host.ack(b, o);
		chk(32'(o), 32'h0);
		rd(IAS_OFF_INSV, 32'h20);
		rd(IAS_OFF_PEND, 32'h0);
		host.ack(b, o);
		chk(32'(b), 32'hAD);
		rd(IAS_OFF_INSV, 32'h0);
		$display("test index done");
		request_lines <= 8'h00;
		apb(1'b1, IAS_OFF_MASK, 32'h04);
		request_lines <= 8'h04;
		repeat (10) @(posedge ref_clk);
		chk(32'(int_out), 32'h0);
		rd(IAS_OFF_PEND, 32'h04);
		apb(1'b1, IAS_OFF_CTRL, 32'h5);
		apb(1'b1, IAS_OFF_MASK, 32'h0);
		wint();
		host.ack(b, o);
		chk(32'(cascade_oe), 32'h1);
		chk(32'(cascade_code_lines), 32'h2);
		host.ack(b, o);
		chk(32'(b), 32'hAA);
		rd(IAS_OFF_INSV, 32'h04);
		$display("test mask done");
		apb(1'b1, IAS_OFF_EOI, 32'h04);
		rd(IAS_OFF_INSV, 32'h0);
		apb(1'b1, IAS_OFF_CTRL, 32'hA);
		rd(IAS_OFF_CTRL, 32'hA);
		request_lines <= 8'h84;
		wint();
		host.ack(b, o);
		chk(32'(b), 32'hCD);
		host.ack(b, o);
		chk(32'(b), 32'hF8);
		host.ack(b, o);
		chk(32'(b), 32'hAB);
		rd(IAS_OFF_INSV, 32'h0);
		$display("test interval done");
		request_lines <= 8'h00;
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (4) @(posedge ref_clk);
		rd(IAS_OFF_CTRL, 32'h0);
		$display("test second reset done");
		final_report();
	end
	initial begin
		#1000000;
		n_fail++;
		final_report();
	end
endmodule
